//--- rtl/sleep_entry_defs.svh
// timing and code constants for the sleep-entry target path
`ifndef SLEEP_ENTRY_DEFS_SVH
`define SLEEP_ENTRY_DEFS_SVH
`define SLP_CLK_PERIOD_NS 50
`define SLP_REC_TIME_US 400
`define SLP_REC_CYCLES ((`SLP_REC_TIME_US * 1000) / `SLP_CLK_PERIOD_NS)
`define SLP_ENTRY_TIME_NS 1000
`define SLP_ENTRY_CYCLES ((`SLP_ENTRY_TIME_NS + `SLP_CLK_PERIOD_NS - 1) / `SLP_CLK_PERIOD_NS)
`define SLP_RSVD_FIRST 8'hf8
`define SLP_RSVD_LAST 8'h86
`define SLP_CNT_W 16
`endif

//--- rtl/sleep_entry_pkg.sv
// types shared by the sleep-entry target path
package sleep_entry_pkg;
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RECV = 6'h02,
    ST_ACK = 6'h04,
    ST_SKIP = 6'h08,
    ST_SLEEP = 6'h10,
    ST_WAKE = 6'h20
  } seq_state_t;
endpackage

//--- rtl/sync2.sv
// two-flop synchroniser for one pin level
`timescale 1ns/1ps
module sync2 (
  input wire logic i_clock, // system clock
  input wire logic i_sys_rst, // synchronous reset
  input wire logic i_async, // pin level
  output logic o_sync // synchronised level
);
  logic meta;

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      meta <= 1'b1;
      o_sync <= 1'b1;
    end
    else
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule // sync2

//--- rtl/i2c_sleep_entry_ack.sv
// sleep-command entry path of a two-wire bus target
// Overview of operation
// - ack the final reserved id, release data after ninth rising clock edge
// - start sleep entry at ninth rising edge; release data when the entry delay in sleep ends
// - data rising while clock high counts as STOP; release may cause one
// - sleep entry completes without any following STOP
// - after wake, ready for bus accesses within at most 400 us
`timescale 1ns/1ps
`include "sleep_entry_defs.svh"
module i2c_sleep_entry_ack
  import sleep_entry_pkg::*;
(
  input wire logic i_clock, // 20 MHz system clock
  input wire logic i_sys_rst, // synchronous reset, active high
  input wire logic i_scl, // bus clock pin
  input wire logic i_sda, // bus data pin level
  input wire logic [6:0] i_own_addr, // our 7-bit target address
  input wire logic i_wake, // wake request (pulse)
  output logic o_sda_out, // data pin output value
  output logic o_sda_oe_n, // data pin enable, low while driving
  output logic o_asleep, // device in sleep state
  output logic o_ready, // device ready for bus accesses
  output logic o_stop_seen, // stop condition detected (pulse)
  output logic o_sleep_req // sleep entry started (pulse)
);
  bus_lines_t pin;
  bus_lines_t prev;
  seq_state_t state;
  seq_state_t next_state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [1:0] phase;
  logic ack_now;
  logic is_last;
  logic [`SLP_CNT_W-1:0] timer;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic byte_done;
  logic [7:0] rx_byte;
  logic scl_sync;
  logic sda_sync;

  sync2 u_sync_scl (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_async(i_scl),
    .o_sync(scl_sync)
  );

  sync2 u_sync_sda (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_async(i_sda),
    .o_sync(sda_sync)
  );

  assign pin = '{scl: scl_sync, sda: sda_sync};

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      prev <= '{scl: 1'b1, sda: 1'b1};
    else
      prev <= pin;
  end

  assign scl_rise = pin.scl & ~prev.scl;
  assign scl_fall = ~pin.scl & prev.scl;
  assign start_cond = pin.scl & prev.scl & prev.sda & ~pin.sda;
  assign stop_cond = pin.scl & prev.scl & ~prev.sda & pin.sda;
  assign rx_byte = {shreg[6:0], pin.sda};
  assign byte_done = scl_rise && bit_cnt == 4'd7;

  // bit counter and shifter; ninth rising edge is the ack edge
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst || start_cond)
    begin
      bit_cnt <= 4'd0;
      shreg <= 8'h00;
    end
    else if (scl_rise)
    begin
      if (bit_cnt == 4'd8)
        bit_cnt <= 4'd0;
      else
      begin
        bit_cnt <= bit_cnt + 4'd1;
        shreg <= rx_byte;
      end
    end
  end

  // sequence: reserved id, our address, restart, final reserved id
  always_ff @(posedge i_clock)
  begin
    // bus traffic is ignored while asleep or recovering
    if (i_sys_rst || stop_cond || state == ST_SLEEP || state == ST_WAKE)
      phase <= 2'd0;
    else if (start_cond && phase == 2'd2)
      phase <= 2'd2;
    else if (byte_done)
    begin
      if (phase == 2'd0 && rx_byte == `SLP_RSVD_FIRST)
        phase <= 2'd1;
      else if (phase == 2'd1 && rx_byte[7:1] == i_own_addr)
        phase <= 2'd2;
      else if (phase == 2'd2 && rx_byte == `SLP_RSVD_LAST)
        phase <= 2'd3;
      else
        phase <= 2'd0;
    end
  end

  always_comb
  begin
    ack_now = 1'b0;
    is_last = 1'b0;
    if (byte_done)
    begin
      ack_now = (phase == 2'd0 && rx_byte == `SLP_RSVD_FIRST)
        || (phase == 2'd1 && rx_byte[7:1] == i_own_addr)
        || (phase == 2'd2 && rx_byte == `SLP_RSVD_LAST);
      is_last = phase == 2'd2 && rx_byte == `SLP_RSVD_LAST;
    end
  end

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (start_cond)
          next_state = ST_RECV;
      ST_RECV:
        if (stop_cond)
          next_state = ST_IDLE;
        else if (byte_done)
          next_state = ack_now ? ST_ACK : ST_SKIP;
      ST_SKIP:
        if (stop_cond)
          next_state = ST_IDLE;
        else if (scl_rise)
          next_state = ST_RECV;
      ST_ACK:
        if (scl_rise && phase == 2'd3)
          next_state = ST_SLEEP;
        else if (scl_rise)
          next_state = ST_RECV;
      ST_SLEEP:
        if (i_wake)
          next_state = ST_WAKE;
      ST_WAKE:
        if (timer == '0)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // entry delay while in sleep; recovery countdown after wake
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      timer <= '0;
    else if (state == ST_ACK && next_state == ST_SLEEP)
      timer <= `SLP_CNT_W'(`SLP_ENTRY_CYCLES);
    else if (state == ST_SLEEP && next_state == ST_WAKE)
      timer <= `SLP_CNT_W'(`SLP_REC_CYCLES - 1);
    else if (timer != '0)
      timer <= timer - `SLP_CNT_W'(1);
  end

  // ack held low past the ninth rising edge; freed when the 20-cycle entry delay in sleep ends
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_sda_out <= 1'b1;
      o_sda_oe_n <= 1'b1;
    end
    else if (state == ST_RECV && byte_done && ack_now)
    begin
      o_sda_out <= 1'b0;
      o_sda_oe_n <= 1'b1;
    end
    else if (state == ST_ACK && scl_fall)
    begin
      o_sda_out <= 1'b0;
      o_sda_oe_n <= 1'b0;
    end
    else if (state == ST_SLEEP && timer <= `SLP_CNT_W'(1))
    begin
      o_sda_out <= 1'b1;
      o_sda_oe_n <= 1'b1;
    end
    // ordinary acks end on the ninth falling edge, so no stop is faked
    else if (state == ST_IDLE || state == ST_WAKE
      || ((state == ST_RECV || state == ST_SKIP) && scl_fall))
    begin
      o_sda_out <= 1'b1;
      o_sda_oe_n <= 1'b1;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_asleep <= 1'b0;
      o_ready <= 1'b1;
      o_stop_seen <= 1'b0;
      o_sleep_req <= 1'b0;
    end
    else
    begin
      o_asleep <= next_state == ST_SLEEP;
      o_ready <= next_state != ST_SLEEP && next_state != ST_WAKE;
      o_stop_seen <= stop_cond;
      o_sleep_req <= state == ST_ACK && next_state == ST_SLEEP;
    end
  end
endmodule // i2c_sleep_entry_ack

//--- testbench/bus_master.sv
// two-wire bus master model
`timescale 1ns/1ps
module bus_master (
  input wire logic i_clock, // clock
  input wire logic i_sda, // data line
  output logic o_scl = 1'b1, // bus clock
  output logic o_sda = 1'b1 // data drive, 1 lets go
);
  task automatic step(input logic c, input logic d);
    o_scl <= c;
    o_sda <= d;
    repeat (4) @(posedge i_clock);
  endtask
  task automatic start();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  // msb first; the ninth clock stays high hi cycles
  task automatic send(input logic [7:0] d, input logic hold, input int hi,
    output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      step(1'b0, d[i]);
      step(1'b1, d[i]);
    end
    step(1'b0, 1'b1);
    ack = !i_sda;
    o_scl <= 1'b1;
    o_sda <= !hold;
    repeat (hi) @(posedge i_clock);
  endtask
endmodule // bus_master

//--- testbench/i2c_sleep_entry_ack_asserts.sv
// port assertions of the sleep-entry path
`timescale 1ns/1ps
module i2c_sleep_entry_ack_asserts (
  input wire logic i_clock, // clock
  input wire logic i_sys_rst, // reset
  input wire logic i_scl, // bus clock
  input wire logic i_sda, // bus data
  input wire logic i_wake, // wake
  input wire logic o_sda_oe_n, // data enable
  input wire logic o_asleep, // asleep
  input wire logic o_ready, // ready
  input wire logic o_stop_seen, // stop pulse
  input wire logic o_sleep_req // entry pulse
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  logic [13:0] rec;
  always_ff @(posedge i_clock)
  begin
    rec <= (i_sys_rst || o_ready || o_asleep) ? 14'h0 : rec + 14'h1;
  end
  property p_held; o_sleep_req |-> !o_sda_oe_n; endproperty
  a_held: assert property (p_held) else $error("ack gone");
  property p_rel; o_sleep_req |-> ##[1:30] o_sda_oe_n; endproperty
  a_rel: assert property (p_rel) else $error("no release");
  property p_enter; o_sleep_req |-> o_asleep && !o_ready; endproperty
  a_enter: assert property (p_enter) else $error("no entry");
  property p_stop; $rose(i_sda) && $past(i_scl) && i_scl && o_ready |-> ##[1:6] o_stop_seen;
  endproperty
  a_stop: assert property (p_stop) else $error("stop missed");
  property p_stay; o_asleep && !i_wake |=> o_asleep; endproperty
  a_stay: assert property (p_stay) else $error("left sleep");
  property p_rec; rec <= 14'h1f41; endproperty
  a_rec: assert property (p_rec) else $error("slow recovery");
  property p_only; $rose(o_asleep) |-> o_sleep_req; endproperty
  a_only: assert property (p_only) else $error("stray sleep");
  c_req: cover property (o_sleep_req);
  c_rdy: cover property ($rose(o_ready));
  c_stp: cover property (o_stop_seen);
endmodule // i2c_sleep_entry_ack_asserts
bind i2c_sleep_entry_ack i2c_sleep_entry_ack_asserts chk (.i_clock, .i_sys_rst, .i_scl,
  .i_sda, .i_wake, .o_sda_oe_n, .o_asleep, .o_ready, .o_stop_seen, .o_sleep_req);

//--- testbench/test_i2c_sleep_entry_ack.sv
// bench for the sleep-entry path
`timescale 1ns/1ps
module test_i2c_sleep_entry_ack;
  logic i_clock = 0, i_sys_rst = 1, i_wake = 0, oe_n, out, asleep, ready, req, scl, msda, pd;
  logic [6:0] own = 7'h2a;
  logic stp;
  wire sda = msda & (oe_n | out);
  int fail_count = 0, n_checks = 0, n_req = 0, rises = 0, n_stop = 0;
  always #25 i_clock = ~i_clock;
  bus_master m (.i_clock, .i_sda(sda), .o_scl(scl), .o_sda(msda));
  i2c_sleep_entry_ack dut (.i_clock, .i_sys_rst, .i_scl(scl), .i_sda(sda), .i_own_addr(own),
    .i_wake, .o_sda_out(out), .o_sda_oe_n(oe_n), .o_asleep(asleep), .o_ready(ready),
    .o_stop_seen(stp), .o_sleep_req(req));
  // counts entries and line rises under a high clock
  always @(posedge i_clock)
  begin
    n_req <= n_req + int'(req === 1'b1);
    n_stop <= n_stop + int'(stp === 1'b1);
    if (scl && sda && !pd) rises <= rises + 1;
    pd <= sda;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic run_seq(input logic [6:0] a, input logic hold, output logic ack);
    m.start();
    m.send(8'hf8, 1'b0, 4, ack);
    m.start();
    m.send({a, 1'b0}, 1'b0, 4, ack);
    m.start();
    m.send(8'h86, hold, 60, ack);
  endtask
  task automatic t_foreign();
    logic ack;
    int s0;
    s0 = n_stop;
    run_seq(own ^ 7'h01, 1'b0, ack);
    check("ack", ack, 0);
    m.stop();
    repeat (40) @(posedge i_clock);
    check("asleep", asleep, 0);
    check("entries", n_req, 0);
    check("stops", n_stop - s0, 1);
  endtask
  task automatic t_sleep(input logic hold);
    logic ack;
    int r0, q0, s0, k;
    r0 = rises;
    q0 = n_req;
    s0 = n_stop;
    run_seq(own, hold, ack);
    check("ack", ack, 1);
    repeat (100) @(posedge i_clock);
    check("entries", n_req - q0, 1);
    check("asleep", asleep, 1);
    check("ready", ready, 0);
    check("rises", rises - r0, !hold);
    check("stops", n_stop - s0, !hold);
    m.stop();
    i_wake <= 1'b1;
    @(posedge i_clock);
    i_wake <= 1'b0;
    k = 0;
    while (ready !== 1'b1 && k < 9000)
    begin
      @(posedge i_clock);
      k++;
    end
    check("recovered", k <= 8002, 1);
    check("awake", asleep, 0);
  endtask
  initial
  begin
    repeat (6) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    repeat (3) @(posedge i_clock);
    t_foreign();
    t_sleep(1'b0);
    t_sleep(1'b1);
    give_verdict();
  end
  initial
  begin
    #2000000;
    fail_count++;
    give_verdict();
  end
endmodule // test_i2c_sleep_entry_ack
